// File: verilog/mcc_regs.vh
// Register layout, reset values and state encodings for the machine-check unit
`ifndef MCC_REGS_VH
`define MCC_REGS_VH

// ==========================================================================
// Register selects on the implementation-register port
`define MCC_SEL_CTL            1'h0
`define MCC_SEL_MCEN           1'h1

// ==========================================================================
// Checkstop control register, bit 0 is the most significant bit
`define MCC_CTL_RESET          32'h80010080
`define MCC_CTL_WR_MASK        32'h8001FFFD
`define MCC_CTL_SRC_MASK       32'h7FF00000
`define MCC_BIT_MASTER         0
`define MCC_BIT_SRC_LO         1
`define MCC_BIT_SRC_HI         11
`define MCC_BIT_EN_LO          15
`define MCC_BIT_EN_HI          25
`define MCC_BIT_PRECHG_OFF     29
`define MCC_BIT_SELFTEST_ERR   30
`define MCC_BIT_PRIO_SNOOP     31
`define MCC_NUM_SRC            11

// ==========================================================================
// Source positions inside the source field, index 0 is source bit 1
`define MCC_SRC_DOUBLE_MC      1
`define MCC_SRC_BUS_ADDR_PAR   6
`define MCC_SRC_BUS_DATA_PAR   7
`define MCC_SRC_CACHE_PAR      8
`define MCC_SRC_DSTORE_PROTO   10

// ==========================================================================
// Machine-check enable register, bits 0 to 3 in the top nibble
`define MCC_MCEN_RESET         4'h0
`define MCC_MCEN_PIN           0
`define MCC_MCEN_CACHE_PAR     1
`define MCC_MCEN_ADDR_PAR      2
`define MCC_MCEN_DATA_PAR      3

// ==========================================================================
// Checkstop sequencing
`define MCC_ST_RUN             2'h0
`define MCC_ST_ENTER           2'h1
`define MCC_ST_FROZEN          2'h2

`endif

// File: verilog/mcc_src_bits.v
// Sticky checkstop source bits with hardware set and software clear
`timescale 1ns/1ps

module mcc_src_bits (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_sys_rst,
  // Control
  input  wire        i_hold,
  input  wire        i_master_en,
  input  wire [0:10] i_enable,
  input  wire [0:10] i_cond,
  // Software write
  input  wire        i_wr,
  input  wire [0:10] i_wdata,
  // Status
  output reg  [0:10] o_src,
  output wire        o_fire
);

  wire [0:10] set_w;

  // ========================================================================
  // One sticky bit per source
  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1) begin : g_src
      // Hardware alone sets; master and own enable both required
      assign set_w[g] = i_master_en & i_enable[g] & i_cond[g]; // RQ1 RQ5

      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          o_src[g] <= 1'b0;
        end else if (!i_hold) begin
          if (set_w[g]) begin
            // Set wins over a clear in the same cycle
            o_src[g] <= 1'b1; // RQ2 RQ4
          end else if (i_wr && !i_wdata[g]) begin
            o_src[g] <= 1'b0; // RQ4
          end
        end
      end
    end
  endgenerate

  assign o_fire = |set_w;

endmodule // mcc_src_bits

// File: verilog/mcc_mc_arb.v
// Machine-check request gating and take-or-checkstop decision
`timescale 1ns/1ps
`include "mcc_regs.vh"

module mcc_mc_arb (
  // Bus error inputs
  input  wire       i_transfer_error_ack,
  input  wire       i_machine_check_in,
  input  wire       i_addr_parity_err,
  input  wire       i_data_parity_err,
  input  wire       i_cache_parity_err,
  // Enables
  input  wire [0:3] i_mc_en,
  input  wire       i_machine_check_enable,
  // Decision
  output wire       o_bus_err,
  output wire       o_req,
  output wire       o_take,
  output wire       o_stop
);

  wire pin_w;
  wire par_w;

  // ========================================================================
  // Gating
  // Pin assertions vanish entirely while the pin enable is clear
  assign pin_w = i_machine_check_in & i_mc_en[`MCC_MCEN_PIN]; // RQ12 RQ19
  assign par_w = (i_cache_parity_err & i_mc_en[`MCC_MCEN_CACHE_PAR]) |
                 (i_addr_parity_err & i_mc_en[`MCC_MCEN_ADDR_PAR]) |
                 (i_data_parity_err & i_mc_en[`MCC_MCEN_DATA_PAR]); // RQ18 RQ19

  assign o_bus_err = i_transfer_error_ack | pin_w; // RQ10 RQ23
  assign o_req     = o_bus_err | par_w; // RQ18

  // ========================================================================
  // Decision
  assign o_take = o_req & i_machine_check_enable; // RQ10 RQ20
  assign o_stop = o_req & ~i_machine_check_enable; // RQ14 RQ18 RQ20

endmodule // mcc_mc_arb

// File: verilog/mcc_core.v
// Machine-check and checkstop unit with its implementation control registers
`timescale 1ns/1ps
`include "mcc_regs.vh"

// Contract
// RQ1: Master enable bit 0 clear disables all checkstops; set defers to each enable. Here it gates only the source-bit checkstops.
// RQ2: Bits 1 to 11 record which checkstop source fired.
// RQ3: Software may write any checkstop enable bit at any time. Here writes are dropped once the unit is frozen.
// RQ4: Software may clear a source bit; a persisting condition sets it again next clock.
// RQ5: Only hardware sets a source bit, with its enable set; writes never set.
// RQ6: Hard reset loads 0x80010080; bit 30 then shows the cache self-test result.
// RQ7: Bit 30 sets when the cache array fails power-on self test.
// RQ8: Bit 29 turns precharge of address-retry and shared-snoop outputs on or off.
// RQ9: Bit 31 picks which snoop hit may use the reserved queue slot.
// RQ10: With machine checks enabled, a bus error input starts a machine check.
// RQ11: One clock after a bus error the data bus is released; data kept.
// RQ12: With the pin enable clear the machine-check input is ignored.
// RQ13: Machine check is taken at once, saving restart address, cancelling pending stores.
// RQ14: Bus machine check beats instruction exceptions; disabled, it causes checkstop.
// RQ15: Checkstop on disabled machine check, checkstop input, or direct-store protocol error.
// RQ16: Checkstop suspends processing and freezes latches within two cycles.
// RQ17: Only reset leaves checkstop.
// RQ18: Parity errors, transfer error and pin are sources; none taken while disabled.
// RQ19: Enable bits 0 to 3: pin, cache parity, address parity, data parity.
// RQ20: An enabled source is an exception only with machine checks on, else checkstop.
// RQ21: The machine check may be signalled imprecisely, unordered to its instruction.
// RQ22: Memory control asserts transfer error for parity or uncorrectable ECC errors.
// RQ23: A zeroed block at a missing address may defer its machine check to writeback.
// RQ24: The checkstop output stays asserted until the next hard reset.
module mcc_core (
  // Clock and hard reset
  input  wire        i_clock,
  input  wire        i_sys_rst,
  // Implementation register port
  input  wire        i_reg_wr,
  input  wire        i_reg_sel,
  input  wire [31:0] i_reg_wdata,
  output reg  [31:0] o_reg_rdata,
  // Power-on cache diagnostic
  input  wire        i_cache_selftest_done,
  input  wire        i_cache_selftest_fail,
  // Processor bus error inputs
  input  wire        i_transfer_error_ack,
  input  wire        i_machine_check_in,
  input  wire        i_addr_parity_err,
  input  wire        i_data_parity_err,
  input  wire        i_cache_parity_err,
  input  wire        i_checkstop_input,
  input  wire        i_dstore_proto_err,
  // Internal checkstop conditions, index 0 is source bit 1
  input  wire [0:10] i_cs_event,
  // Core state
  input  wire        i_machine_check_enable,
  input  wire        i_mc_return,
  input  wire [31:0] i_next_fetch_addr,
  // Snoop queue
  input  wire        i_snoop_hit,
  input  wire        i_priority_snoop_request,
  input  wire        i_read_pending,
  // Exception outputs
  output reg         o_mc_exception,
  output reg         o_cancel_stores,
  output reg  [31:0] o_save_restore_addr,
  // Checkstop outputs
  output reg         o_checkstop_output,
  output reg         o_suspend,
  output reg         o_freeze,
  // Bus control outputs
  output reg         o_data_bus_hiz,
  output reg         o_retry_shared_precharge_en,
  output reg         o_priority_snoop_enable,
  output reg         o_reserved_slot_grant
);

  // ========================================================================
  // Declarations
  reg  [0:31] ctl_r;
  reg  [0:31] ctl_nxt;
  reg  [0:3]  mcen_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         mc_busy_r;
  wire [0:10] src_w;
  wire [0:10] cond_w;
  wire        src_fire_w;
  wire        bus_err_w;
  wire        mc_req_w;
  wire        mc_take_w;
  wire        mc_stop_w;
  wire        stop_req_w;
  wire        running_w;
  wire        hold_w;
  wire        wr_ctl_w;
  wire        wr_mcen_w;
  wire [0:31] wdata_w;
  wire [0:31] rd_ctl_w;

  assign wdata_w   = i_reg_wdata;
  // Frozen latches accept no write so the failure state survives for analysis
  assign hold_w    = (state_r == `MCC_ST_FROZEN); // RQ16
  assign running_w = (state_r == `MCC_ST_RUN);
  assign wr_ctl_w  = i_reg_wr && !hold_w && (i_reg_sel == `MCC_SEL_CTL);
  assign wr_mcen_w = i_reg_wr && !hold_w && (i_reg_sel == `MCC_SEL_MCEN);

  // ========================================================================
  // Machine-check decision
  mcc_mc_arb u_arb (
    .i_transfer_error_ack   (i_transfer_error_ack),
    .i_machine_check_in     (i_machine_check_in),
    .i_addr_parity_err      (i_addr_parity_err),
    .i_data_parity_err      (i_data_parity_err),
    .i_cache_parity_err     (i_cache_parity_err),
    .i_mc_en                (mcen_r),
    .i_machine_check_enable (i_machine_check_enable),
    .o_bus_err              (bus_err_w),
    .o_req                  (mc_req_w),
    .o_take                 (mc_take_w),
    .o_stop                 (mc_stop_w)
  );

  // ========================================================================
  // Checkstop source conditions
  // Bus and cache sources come straight from the error inputs; a second
  // request while the handler is still running counts as a double check.
  genvar g;
  generate
    for (g = 0; g < `MCC_NUM_SRC; g = g + 1) begin : g_cond
      if (g == `MCC_SRC_DOUBLE_MC) begin : g_dbl
        assign cond_w[g] = i_cs_event[g] | (mc_take_w & mc_busy_r);
      end else if (g == `MCC_SRC_BUS_ADDR_PAR) begin : g_ap
        assign cond_w[g] = i_cs_event[g] | i_addr_parity_err;
      end else if (g == `MCC_SRC_BUS_DATA_PAR) begin : g_dp
        assign cond_w[g] = i_cs_event[g] | i_data_parity_err;
      end else if (g == `MCC_SRC_CACHE_PAR) begin : g_cp
        assign cond_w[g] = i_cs_event[g] | i_cache_parity_err;
      end else if (g == `MCC_SRC_DSTORE_PROTO) begin : g_ds
        assign cond_w[g] = i_cs_event[g] | i_dstore_proto_err;
      end else begin : g_ext
        assign cond_w[g] = i_cs_event[g];
      end
    end
  endgenerate

  mcc_src_bits u_src (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_hold      (hold_w),
    .i_master_en (ctl_r[`MCC_BIT_MASTER]),
    .i_enable    (ctl_r[`MCC_BIT_EN_LO:`MCC_BIT_EN_HI]),
    .i_cond      (cond_w),
    .i_wr        (wr_ctl_w),
    .i_wdata     (wdata_w[`MCC_BIT_SRC_LO:`MCC_BIT_SRC_HI]),
    .o_src       (src_w),
    .o_fire      (src_fire_w)
  );

  // ========================================================================
  // Checkstop control register
  // Source bits live in the sticky-bit module, so this copy keeps them zero.
  always @* begin
    ctl_nxt = ctl_r;
    if (wr_ctl_w) begin
      ctl_nxt = (ctl_r & ~`MCC_CTL_WR_MASK) | (wdata_w & `MCC_CTL_WR_MASK); // RQ3
    end
    ctl_nxt = ctl_nxt & ~`MCC_CTL_SRC_MASK; // RQ5
    if (i_cache_selftest_done && i_cache_selftest_fail) begin
      ctl_nxt[`MCC_BIT_SELFTEST_ERR] = 1'b1; // RQ7
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctl_r <= `MCC_CTL_RESET; // RQ6
    end else if (!hold_w) begin
      ctl_r <= ctl_nxt; // RQ6
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      mcen_r <= `MCC_MCEN_RESET;
    end else if (wr_mcen_w) begin
      mcen_r <= wdata_w[0:3]; // RQ19
    end
  end

  assign rd_ctl_w = ctl_r | {1'b0, src_w, 20'h00000};

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_sel == `MCC_SEL_CTL) begin
      o_reg_rdata <= rd_ctl_w; // RQ2
    end else begin
      o_reg_rdata <= {mcen_r, 28'h0000000};
    end
  end

  // ========================================================================
  // Checkstop sequencing
  // Entry on a disabled machine check, the external checkstop input, a
  // direct-store protocol error, or any enabled source firing.
  assign stop_req_w = mc_stop_w | i_checkstop_input | i_dstore_proto_err |
                      src_fire_w; // RQ15 RQ14 RQ20

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `MCC_ST_RUN: begin
        if (stop_req_w) begin
          state_nxt = `MCC_ST_ENTER; // RQ15
        end
      end
      `MCC_ST_ENTER: begin
        state_nxt = `MCC_ST_FROZEN; // RQ16
      end
      `MCC_ST_FROZEN: begin
        // No way out but reset
        state_nxt = `MCC_ST_FROZEN; // RQ17
      end
      default: begin
        state_nxt = `MCC_ST_FROZEN;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r            <= `MCC_ST_RUN;
      o_checkstop_output <= 1'b0;
      o_suspend          <= 1'b0;
      o_freeze           <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (running_w && stop_req_w) begin
        o_checkstop_output <= 1'b1; // RQ15 RQ24
        o_suspend          <= 1'b1; // RQ16
      end
      if (state_nxt == `MCC_ST_FROZEN) begin
        o_freeze <= 1'b1; // RQ16
      end
    end
  end

  // ========================================================================
  // Machine-check exception entry
  // Taken the cycle after the request, whatever the core is doing; the
  // exception is not ordered against the instruction that issued the bus
  // operation, and it overrides that instruction's own exceptions.
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_mc_exception      <= 1'b0;
      o_cancel_stores     <= 1'b0;
      o_save_restore_addr <= 32'h00000000;
      mc_busy_r           <= 1'b0;
    end else begin
      o_mc_exception  <= running_w && mc_take_w && !stop_req_w; // RQ13 RQ14 RQ21
      o_cancel_stores <= running_w && mc_take_w && !stop_req_w; // RQ13
      if (running_w && mc_take_w && !stop_req_w) begin
        o_save_restore_addr <= i_next_fetch_addr; // RQ13
        mc_busy_r           <= 1'b1;
      end else if (i_mc_return) begin
        mc_busy_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Data bus release
  // Released one clock after a bus error; data already captured stays valid
  // since nothing here touches the register file or cache.
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_data_bus_hiz <= 1'b0;
    end else begin
      o_data_bus_hiz <= bus_err_w; // RQ11
    end
  end

  // ========================================================================
  // Snoop and precharge control
  // Precharge is on while the bit is clear; the bit name reads as "off".
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_retry_shared_precharge_en <= 1'b0;
      o_priority_snoop_enable     <= 1'b0;
      o_reserved_slot_grant       <= 1'b0;
    end else begin
      o_retry_shared_precharge_en <= ~ctl_r[`MCC_BIT_PRECHG_OFF]; // RQ8
      o_priority_snoop_enable     <= ctl_r[`MCC_BIT_PRIO_SNOOP]; // RQ9
      if (ctl_r[`MCC_BIT_PRIO_SNOOP]) begin
        o_reserved_slot_grant <= i_snoop_hit & i_priority_snoop_request; // RQ9
      end else begin
        o_reserved_slot_grant <= i_snoop_hit & i_read_pending; // RQ9
      end
    end
  end

endmodule // mcc_core

// File: testbench/mcc_core_asserts.sv
// Port-level checker for machine-check and checkstop timing
`timescale 1ns/1ps

module mcc_core_asserts (
  // Clock and reset
  input wire        i_clock,
  input wire        i_sys_rst,
  // Watched inputs
  input wire        i_transfer_error_ack,
  input wire        i_checkstop_input,
  input wire        i_dstore_proto_err,
  input wire [0:10] i_cs_event,
  input wire        i_machine_check_enable,
  input wire [31:0] i_next_fetch_addr,
  // Watched outputs
  input wire        o_mc_exception,
  input wire        o_cancel_stores,
  input wire [31:0] o_save_restore_addr,
  input wire        o_checkstop_output,
  input wire        o_suspend,
  input wire        o_freeze,
  input wire        o_data_bus_hiz
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================================
  // Assertions
  hiz_after_err_a: assert property (
    i_transfer_error_ack && !o_suspend |=> o_data_bus_hiz)
    else $error("data bus not released after bus error");
  mc_take_a: assert property (
    i_transfer_error_ack && i_machine_check_enable && !i_checkstop_input
    && !i_dstore_proto_err && i_cs_event == 11'h0 && !o_suspend
    |=> o_mc_exception && o_cancel_stores
    && o_save_restore_addr == $past(i_next_fetch_addr))
    else $error("bus error not taken as machine check");
  me_off_stop_a: assert property (
    i_transfer_error_ack && !i_machine_check_enable
    |=> o_checkstop_output && !o_mc_exception)
    else $error("disabled machine check did not checkstop");
  no_take_a: assert property (
    !i_machine_check_enable |=> !o_mc_exception)
    else $error("machine check taken while disabled");
  ckin_stop_a: assert property (i_checkstop_input |=> o_checkstop_output)
    else $error("checkstop input ignored");
  dstore_stop_a: assert property (i_dstore_proto_err |=> o_checkstop_output)
    else $error("protocol error did not checkstop");
  stop_sticky_a: assert property (o_checkstop_output |=> o_checkstop_output)
    else $error("checkstop output dropped before reset");
  freeze_delay_a: assert property (
    $rose(o_checkstop_output) |-> !o_freeze ##1 o_freeze)
    else $error("latches not frozen one cycle after checkstop");
  suspend_pair_a: assert property (o_suspend == o_checkstop_output)
    else $error("suspend and checkstop output differ");
  frozen_quiet_a: assert property (o_freeze |-> !o_mc_exception)
    else $error("machine check while frozen");

  // Main scenarios reached
  cover property (o_mc_exception);
  cover property ($rose(o_freeze));
  cover property (o_data_bus_hiz && !o_suspend);
endmodule // mcc_core_asserts

bind mcc_core mcc_core_asserts u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_transfer_error_ack(i_transfer_error_ack), .i_checkstop_input(i_checkstop_input),
  .i_dstore_proto_err(i_dstore_proto_err), .i_cs_event(i_cs_event),
  .i_machine_check_enable(i_machine_check_enable), .i_next_fetch_addr(i_next_fetch_addr),
  .o_mc_exception(o_mc_exception), .o_cancel_stores(o_cancel_stores),
  .o_save_restore_addr(o_save_restore_addr), .o_checkstop_output(o_checkstop_output),
  .o_suspend(o_suspend), .o_freeze(o_freeze), .o_data_bus_hiz(o_data_bus_hiz));

// File: testbench/mcc_mem_model.sv
// Memory controller model that flags failing accesses on the bus
`timescale 1ns/1ps

module mcc_mem_model (
  // Access from the bench
  input  wire i_access,
  input  wire i_ecc_err,
  input  wire i_par_err,
  // Bus error report
  output reg  o_transfer_error_ack
);
  // Reported in the same tenure, so the error terminates the failing access
  always @* begin
    o_transfer_error_ack = i_access & (i_ecc_err | i_par_err);
  end
endmodule // mcc_mem_model

// File: testbench/test_mcc_core.sv
// Self-checking bench for the machine-check and checkstop unit
`timescale 1ns/1ps

module test_mcc_core;
  // ==========================================================================
  // Signals
  reg        i_clock, i_sys_rst, i_reg_wr, i_reg_sel, st_done, st_fail, acc, ecc, mpar;
  reg        machine_check_in, apar, dpar, cpar, ckin, dse, me, ret, hit, preq, pend, t;
  reg [31:0] wdata, nfa;
  reg [0:10] cse;
  reg [3:0]  m;
  wire       transfer_error_ack, mc, cst, ckst, sus, frz, hiz, pre, pse, grant;
  wire[31:0] rdata, sra;
  integer    n_mismatch, n_tests, k, j;

  mcc_mem_model u_mem (.i_access(acc), .i_ecc_err(ecc), .i_par_err(mpar),
    .o_transfer_error_ack(transfer_error_ack));
  mcc_core uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
    .i_reg_sel(i_reg_sel), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_cache_selftest_done(st_done), .i_cache_selftest_fail(st_fail),
    .i_transfer_error_ack(transfer_error_ack), .i_machine_check_in(machine_check_in), .i_addr_parity_err(apar),
    .i_data_parity_err(dpar), .i_cache_parity_err(cpar), .i_checkstop_input(ckin),
    .i_dstore_proto_err(dse), .i_cs_event(cse), .i_machine_check_enable(me),
    .i_mc_return(ret), .i_next_fetch_addr(nfa), .i_snoop_hit(hit),
    .i_priority_snoop_request(preq), .i_read_pending(pend), .o_mc_exception(mc),
    .o_cancel_stores(cst), .o_save_restore_addr(sra), .o_checkstop_output(ckst),
    .o_suspend(sus), .o_freeze(frz), .o_data_bus_hiz(hiz),
    .o_retry_shared_precharge_en(pre), .o_priority_snoop_enable(pse),
    .o_reserved_slot_grant(grant));

  // ==========================================================================
  // Helpers
  function xreq(input a_t, a_p, a_c, a_a, a_d, input [3:0] e);
    xreq = a_t | (a_p & e[3]) | (a_c & e[2]) | (a_a & e[1]) | (a_d & e[0]);
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task tick;
    @(negedge i_clock);
  endtask

  task rst;
    begin
      i_sys_rst = 1;
      repeat (16) tick;
      i_sys_rst = 0;
    end
  endtask

  task wr(input s, input [31:0] d);
    begin
      i_reg_sel = s;
      wdata = d;
      i_reg_wr = 1;
      tick;
      i_reg_wr = 0;
    end
  endtask

  // Read data trails the select by one edge, so two edges settle it
  task rd(input s, input [31:0] e);
    begin
      i_reg_sel = s;
      tick;
      tick;
      chk(rdata, e);
    end
  endtask

  task wrap_up;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    i_clock = 0;
    forever #2.5 i_clock = ~i_clock;
  end

  initial begin
    #500000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {i_sys_rst, i_reg_wr, i_reg_sel, st_done, st_fail, acc, ecc, mpar} = 8'h80;
    {machine_check_in, apar, dpar, cpar, ckin, dse, me, ret, hit, preq, pend} = 11'h000;
    wdata = 0;
    nfa = 0;
    cse = 0;
    n_mismatch = 0;
    n_tests = 0;
    k = $urandom(32'hD4DF831E);
    rst;
    rd(0, 32'h80010080);
    rd(1, 32'h0);
    wr(0, 32'hFFFFFFFF);
    rd(0, 32'h8001FFFD);
    chk(pre, 0);
    chk(pse, 1);
    wr(0, 32'h0);
    rd(0, 32'h0);
    chk(pre, 1);
    // Master enable and all source enables off: no internal condition may stop the unit
    cse = 11'h7FF;
    tick;
    cse = 0;
    tick;
    chk(ckst, 0);
    rd(0, 32'h0);
    for (k = 0; k < 64; k = k + 1) begin
      if (k % 32 == 0)
        wr(0, k / 32);
      {hit, preq, pend} = $urandom;
      tick;
      chk(grant, hit & (k >= 32 ? preq : pend));
    end
    me = 1;
    for (k = 0; k < 24; k = k + 1) begin
      m = $urandom;
      wr(1, {m, 28'h0});
      rd(1, {m, 28'h0});
      for (j = 0; j < 8; j = j + 1) begin
        {acc, ecc, mpar, machine_check_in, apar, dpar, cpar, ret} = $urandom;
        nfa = $urandom;
        t = acc & (ecc | mpar);
        tick;
        chk(mc, xreq(t, machine_check_in, cpar, apar, dpar, m));
        chk(cst, xreq(t, machine_check_in, cpar, apar, dpar, m));
        chk(hiz, t | (machine_check_in & m[3]));
        if (mc === 1'b1)
          chk(sra, nfa);
      end
    end
    {acc, ecc, mpar, machine_check_in, apar, dpar, cpar, ret} = 8'h00;
    rst;
    st_done = 1;
    st_fail = 1;
    tick;
    st_done = 0;
    st_fail = 0;
    rd(0, 32'h80010082);
    wr(0, 32'h0);
    rd(0, 32'h2);
    // Each checkstop cause in turn, then writes must bounce off the frozen unit
    for (k = 0; k < 4; k = k + 1) begin
      rst;
      i_reg_sel = 0;
      me = (k != 2);
      ckin = (k == 0);
      dse = (k == 1);
      acc = (k == 2);
      ecc = (k == 2);
      cse[0] = (k == 3);
      tick;
      {ckin, dse, acc, ecc} = 4'h0;
      cse = 0;
      chk(ckst, 1);
      chk(sus, 1);
      chk(frz, 0);
      chk(mc, 0);
      tick;
      chk(frz, 1);
      wr(0, 32'h0);
      repeat (20) tick;
      chk(ckst, 1);
      rd(0, k == 3 ? 32'hC0010080 : 32'h80010080);
    end
    rst;
    chk(ckst, 0);
    wrap_up;
  end
endmodule // test_mcc_core
